// >>> bench/dcs_top_test.sv
// Register and channel testbench for the count and collision status block
`timescale 1ns/100ps
`include "dcs_cfg.svh"
module dcs_top_test;
    import dcs_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [7:0] chan_xfer_done = 8'h00;
    logic [7:0] periph_collision = 8'h00;
    logic [7:0] ram_collision = 8'h00;
    logic [7:0] chan_xfer_req;
    logic [7:0] chan_block_done;
    int bad_count = 0;
    int n_checks = 0;

    always #10 aclk = ~aclk;

    dcs_top #(.NCH(8)) i_dcs_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .chan_xfer_done(chan_xfer_done),
        .periph_collision(periph_collision), .ram_collision(ram_collision),
        .chan_xfer_req(chan_xfer_req), .chan_block_done(chan_block_done));

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask : check

    task automatic hang(input string msg);
        bad_count++;
        $display("wrong value at %0t: %s timed out", $time, msg);
        results();
    endtask : hang

    // ****************************************
    // Bus tasks
    // ****************************************
    // Collision pulses ride on the cycle that offers the write, so they
    // land on the same edge that takes it
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             input logic [7:0] pc, input logic [7:0] rc,
                             input logic [1:0] er);
        int n;
        logic aw_t;
        logic w_t;
        aw_t = 1'b0;
        w_t = 1'b0;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        periph_collision <= pc;
        ram_collision <= rc;
        do
        begin
            @(posedge aclk);
            periph_collision <= 8'h00;
            ram_collision <= 8'h00;
            if (s_axi_awready)
                aw_t = 1'b1;
            if (s_axi_wready)
                w_t = 1'b1;
            if (aw_t)
                s_axi_awvalid <= 1'b0;
            if (w_t)
                s_axi_wvalid <= 1'b0;
            n++;
        end while (!(aw_t && w_t) && n < 50);
        while (!s_axi_bvalid && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        if (n >= 100)
            hang("write");
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed,
                            input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 100);
        if (n >= 100)
            hang("read");
        s_axi_rready <= 1'b0;
        check({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
        if (er == `DCS_RESP_OKAY)
            check(s_axi_rdata, ed, "read data");
    endtask : axi_read

    // ****************************************
    // Channel run: feed transfers until the block completes
    // ****************************************
    task automatic run_chan(input int ch, input logic [9:0] cnt);
        int n;
        int taken;
        logic [7:0] sel;
        sel = 8'h01 << ch;
        taken = 0;
        axi_write(`DCS_CNT_BASE + 12'(4 * ch), {22'h0, cnt}, 8'h00, 8'h00,
                  `DCS_RESP_OKAY);
        axi_write(`DCS_ENA_OFF, {24'h0, sel}, 8'h00, 8'h00, `DCS_RESP_OKAY);
        axi_read(`DCS_BUSY_OFF, {24'h0, sel}, `DCS_RESP_OKAY);
        chan_xfer_done <= sel;
        for (n = 0; n < 2000 && chan_block_done[ch] !== 1'b1; n++)
        begin
            @(posedge aclk);
            if (chan_xfer_done[ch] && chan_xfer_req[ch])
                taken++;
        end
        if (n >= 2000)
            hang("block done");
        chan_xfer_done <= 8'h00;
        @(posedge aclk);
        check({31'h0, chan_block_done[ch]}, 32'h0, "done pulse width");
        check(32'(taken), 32'(cnt) + 32'h1, "transfer count");
        check({31'h0, chan_xfer_req[ch]}, 32'h0, "request after done");
        axi_write(`DCS_ENA_OFF, 32'h0, 8'h00, 8'h00, `DCS_RESP_OKAY);
    endtask : run_chan

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            axi_read(`DCS_CNT_BASE + 12'(4 * i), 32'h0, `DCS_RESP_OKAY);
        axi_read(`DCS_STAT_OFF, 32'h0, `DCS_RESP_OKAY);
        // Upper bits written as ones must read back as zero
        for (int i = 0; i < 8; i++)
            axi_write(`DCS_CNT_BASE + 12'(4 * i), 32'hFFFF_FC00 | (i * 100 + 3),
                      8'h00, 8'h00, `DCS_RESP_OKAY);
        for (int i = 0; i < 8; i++)
            axi_read(`DCS_CNT_BASE + 12'(4 * i), 32'(i * 100 + 3),
                     `DCS_RESP_OKAY);
        axi_write(`DCS_CNT_BASE, 32'h0000_FFFF, 8'h00, 8'h00, `DCS_RESP_OKAY);
        axi_read(`DCS_CNT_BASE, 32'h0000_03FF, `DCS_RESP_OKAY);
        for (int i = 0; i < 8; i++)
        begin
            axi_write(`DCS_STAT_OFF, 32'h0, 8'h01 << i, 8'h80 >> i,
                      `DCS_RESP_OKAY);
            axi_read(`DCS_STAT_OFF, (32'h100 << i) | (32'h80 >> i),
                     `DCS_RESP_OKAY);
            axi_write(`DCS_STAT_OFF, 32'h100 << i, 8'h00, 8'h00,
                      `DCS_RESP_OKAY);
            axi_read(`DCS_STAT_OFF, 32'h80 >> i, `DCS_RESP_OKAY);
            axi_write(`DCS_STAT_OFF, 32'hFFFF, 8'h00, 8'h00,
                      `DCS_RESP_OKAY);
            axi_read(`DCS_STAT_OFF, 32'h0, `DCS_RESP_OKAY);
        end
        // Clear and fresh collision on one peripheral flag and one RAM flag in one cycle
        axi_write(`DCS_STAT_OFF, 32'h0, 8'h02, 8'h10, `DCS_RESP_OKAY);
        axi_write(`DCS_STAT_OFF, 32'h210, 8'h02, 8'h10,
                  `DCS_RESP_OKAY);
        axi_read(`DCS_STAT_OFF, 32'h210, `DCS_RESP_OKAY);
        axi_write(`DCS_STAT_OFF, 32'h210, 8'h00, 8'h00, `DCS_RESP_OKAY);
        axi_read(`DCS_STAT_OFF, 32'h0, `DCS_RESP_OKAY);
        axi_write(12'h100, 32'h1, 8'h00, 8'h00, `DCS_RESP_SLVERR);
        axi_read(12'h100, 32'h0, `DCS_RESP_SLVERR);
        run_chan(0, 10'h000);
        run_chan(3, 10'h005);
        run_chan(7, 10'h3FF);
        results();
    end
endmodule : dcs_top_test

// >>> src/dcs_cfg.svh
// Register offsets, field positions, reset values and response codes
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define DCS_CNT_BASE 12'h000
`define DCS_STAT_OFF 12'h040
`define DCS_ENA_OFF 12'h044
`define DCS_BUSY_OFF 12'h048
`define DCS_ADDR_W 12

// ****************************************
// Fields and reset values
// ****************************************
`define DCS_CNT_W 10
`define DCS_CNT_RST 10'h000
`define DCS_PFLAG_LSB 8
`define DCS_RWCOL_LSB 0
`define DCS_STAT_RST 16'h0000
`define DCS_RESP_OKAY 2'h0
`define DCS_RESP_SLVERR 2'h2

`endif

// >>> src/dcs_chan_seq.sv
// One channel's transfer sequencer: performs count plus one transfers
`timescale 1ns/100ps
`include "dcs_cfg.svh"
module dcs_chan_seq
#(
    parameter int CNT_W = `DCS_CNT_W
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic enable,
    input wire logic [CNT_W-1:0] count,
    input wire logic xfer_done,
    // Status
    output logic xfer_req,
    output logic block_done,
    output logic [CNT_W:0] remaining
);
    import dcs_pkg::*;
    dcs_chan_state_t state, next_state;
    logic [CNT_W:0] next_remaining;
    logic next_block_done;

    always_comb
    begin
        next_state = state;
        next_remaining = remaining;
        next_block_done = 1'b0;
        case (state)
            DCS_IDLE:
            begin
                if (enable)
                begin
                    // Count of zero still gives one transfer
                    next_remaining = {1'b0, count} + 1'b1;
                    next_state = DCS_XFER;
                end
            end
            DCS_XFER:
            begin
                if (!enable)
                    next_state = DCS_IDLE;
                else if (xfer_done)
                begin
                    next_remaining = remaining - 1'b1;
                    if (remaining == {{CNT_W{1'b0}}, 1'b1})
                    begin
                        next_state = DCS_DONE;
                        next_block_done = 1'b1;
                    end
                end
            end
            DCS_DONE:
            begin
                // Wait for disable before another block can start
                if (!enable)
                    next_state = DCS_IDLE;
            end
            default:
                next_state = DCS_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= DCS_IDLE;
            remaining <= '0;
            block_done <= 1'b0;
        end
        else
        begin
            state <= next_state;
            remaining <= next_remaining;
            block_done <= next_block_done;
        end
    end

    assign xfer_req = (state == DCS_XFER) && enable;

    a_block_len: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == DCS_IDLE && enable) |=>
        remaining == {1'b0, $past(count)} + 1'b1)
        else $error("block length is not count plus one");
endmodule : dcs_chan_seq

// >>> src/dcs_pkg.sv
// Types shared by the count and collision status block
package dcs_pkg;
    typedef enum logic [1:0] {DCS_IDLE, DCS_XFER, DCS_DONE} dcs_chan_state_t;
endpackage : dcs_pkg

// >>> src/dcs_top.sv
// Channel transfer counts and write collision status behind AXI4-Lite
`timescale 1ns/100ps
`include "dcs_cfg.svh"
module dcs_top
#(
    parameter int NCH = 8
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [`DCS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [`DCS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Channel side
    input wire logic [NCH-1:0] chan_xfer_done,
    input wire logic [NCH-1:0] periph_collision,
    input wire logic [NCH-1:0] ram_collision,
    output logic [NCH-1:0] chan_xfer_req,
    output logic [NCH-1:0] chan_block_done
);
    import dcs_pkg::*;
    // ****************************************
    // Register state
    // ****************************************
    logic [`DCS_CNT_W-1:0] transfer_count_field [NCH];
    logic [`DCS_CNT_W-1:0] next_count [NCH];
    logic [NCH-1:0] periph_write_collision_flag;
    logic [NCH-1:0] next_pflag;
    logic [NCH-1:0] ram_write_collision_flag;
    logic [NCH-1:0] next_rwcol;
    logic [NCH-1:0] chan_enable;
    logic [NCH-1:0] next_enable;
    logic [NCH-1:0] chan_busy;

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [`DCS_ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic wr_fire;
    logic [`DCS_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;

    // Each channel is taken once, held until both arrive
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DCS_RESP_OKAY;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
        end
    end

    // Write commits in the cycle both halves are present
    assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_data = w_held ? w_data : s_axi_wdata;
    assign wr_strb = w_held ? w_strb : s_axi_wstrb;
    assign wr_fire = !s_axi_bvalid && (aw_held || s_axi_awvalid)
        && (w_held || s_axi_wvalid);
    assign wr_hit = (wr_addr < `DCS_CNT_BASE + 12'(4 * NCH))
        || wr_addr == `DCS_STAT_OFF || wr_addr == `DCS_ENA_OFF;

    // ****************************************
    // Register updates
    // ****************************************
    always_comb
    begin
        next_pflag = periph_write_collision_flag;
        next_rwcol = ram_write_collision_flag;
        next_enable = chan_enable;
        for (int i = 0; i < NCH; i++)
            next_count[i] = transfer_count_field[i];
        if (wr_fire)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (wr_addr == `DCS_CNT_BASE + 12'(4 * i))
                begin
                    // Only bits 9:0 exist; upper lanes are dropped
                    if (wr_strb[0])
                        next_count[i][7:0] = wr_data[7:0];
                    if (wr_strb[1])
                        next_count[i][9:8] = wr_data[9:8];
                end
            end
            // Writing one clears a flag; zeros leave it alone
            if (wr_addr == `DCS_STAT_OFF)
            begin
                if (wr_strb[1])
                    next_pflag = next_pflag & ~wr_data[15:8];
                if (wr_strb[0])
                    next_rwcol = next_rwcol & ~wr_data[7:0];
            end
            if (wr_addr == `DCS_ENA_OFF && wr_strb[0])
                next_enable = wr_data[NCH-1:0];
        end
        // Hardware set is applied last so it beats a clear
        next_pflag = next_pflag | periph_collision;
        next_rwcol = next_rwcol | ram_collision;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < NCH; i++)
                transfer_count_field[i] <= `DCS_CNT_RST;
            periph_write_collision_flag <= '0;
            ram_write_collision_flag <= '0;
            chan_enable <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
                transfer_count_field[i] <= next_count[i];
            periph_write_collision_flag <= next_pflag;
            ram_write_collision_flag <= next_rwcol;
            chan_enable <= next_enable;
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    logic [31:0] rd_word;
    logic rd_hit;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_rvalid;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb
    begin
        rd_word = '0;
        rd_hit = 1'b0;
        for (int i = 0; i < NCH; i++)
        begin
            if (s_axi_araddr == `DCS_CNT_BASE + 12'(4 * i))
            begin
                rd_word = {22'h0, transfer_count_field[i]};
                rd_hit = 1'b1;
            end
        end
        if (s_axi_araddr == `DCS_STAT_OFF)
        begin
            rd_word = {16'h0000, periph_write_collision_flag,
                ram_write_collision_flag};
            rd_hit = 1'b1;
        end
        if (s_axi_araddr == `DCS_ENA_OFF)
        begin
            rd_word = {24'h000000, chan_enable};
            rd_hit = 1'b1;
        end
        if (s_axi_araddr == `DCS_BUSY_OFF)
        begin
            rd_word = {24'h000000, chan_busy};
            rd_hit = 1'b1;
        end
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_rvalid = s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rdata = rd_word;
            next_rresp = rd_hit ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
            next_rvalid = 1'b1;
        end
        else if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `DCS_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
        end
        else
        begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_rvalid <= next_rvalid;
        end
    end

    // ****************************************
    // Channel sequencers
    // ****************************************
    // A count written mid-block is not seen until the next block starts
    for (genvar g = 0; g < NCH; g++)
    begin : g_chan
        dcs_chan_seq #(.CNT_W(`DCS_CNT_W)) u_seq (
            .aclk(aclk),
            .aresetn(aresetn),
            .enable(chan_enable[g]),
            .count(transfer_count_field[g]),
            .xfer_done(chan_xfer_done[g]),
            .xfer_req(chan_xfer_req[g]),
            .block_done(chan_block_done[g]),
            .remaining()
        );
        assign chan_busy[g] = chan_xfer_req[g];
    end

    // ****************************************
    // Checks
    // ****************************************
    a_periph_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        periph_collision[0] |=> periph_write_collision_flag[0])
        else $error("peripheral collision not flagged");
    a_rwcol_set: assert property (@(posedge aclk) disable iff (!aresetn)
        ram_collision[NCH-1] |=> ram_write_collision_flag[NCH-1])
        else $error("ram collision not flagged");
    a_flag_no_sw_set: assert property (@(posedge aclk) disable iff (!aresetn)
        !ram_write_collision_flag[0] && !ram_collision[0]
        |=> !ram_write_collision_flag[0])
        else $error("flag rose without a collision");
    a_clear_wins_not: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_addr == `DCS_STAT_OFF && wr_strb[1] && wr_data[9]
        && periph_collision[1] |=> periph_write_collision_flag[1])
        else $error("collision lost under clear");
    a_cnt_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && $past(s_axi_araddr) == `DCS_CNT_BASE
        && $rose(s_axi_rvalid) |-> s_axi_rdata[31:10] == '0)
        else $error("count upper bits not zero");
    a_cnt_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_addr == `DCS_CNT_BASE && wr_strb[1:0] == 2'h3
        |=> transfer_count_field[0] == $past(wr_data[9:0]))
        else $error("count write not stored");
    a_sw_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_addr == `DCS_STAT_OFF && wr_strb[0] && wr_data[2]
        && !ram_collision[2] |=> !ram_write_collision_flag[2])
        else $error("flag not cleared by software");
    a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `DCS_STAT_OFF
        |=> s_axi_rvalid ##0 s_axi_rdata[15:8] ==
        $past(periph_write_collision_flag))
        else $error("status read wrong");
endmodule : dcs_top
